// *** dtc_top.sv ***
// dual timer/counter with mode control and an ahb-lite register slave
//
// Notes on behaviour
// - timer one gated: counts only while irq pin one high and run one set
// - timer one: select clear counts clock ticks, set counts count pin falls
// - mode bits 5:4 select timer one's counting mode
// - timer zero gated: counts only while irq pin zero high and run zero set
// - timer zero: select clear counts clock ticks, set counts count pin falls
// - mode bits 1:0 select timer zero's mode, same encoding
// - mode 00: low byte acts as a five-bit prescaler before the high byte
// - mode 01: full sixteen-bit count, no prescale
// - mode 10: eight-bit low byte reloads from high byte on overflow
// - mode 11: timer zero low byte is eight-bit with its own controls
// - mode 11: timer zero high byte counts clock ticks under run one
// - timer one in mode 11 stops and holds its value
// - timer zero low and high bytes readable and writable at 8ah, 8ch
// - timer one low and high bytes readable and writable at 8bh, 8dh
// - overflow flags set on overflow, cleared on service, software writable
// - run bit one turns timer on, zero turns it off
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dtc_top
    import dtc_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // external pins
    input  wire logic        ext_irq_pin_zero,
    input  wire logic        ext_irq_pin_one,
    input  wire logic        count_input_zero,
    input  wire logic        count_input_one,
    // interrupt service entry, one-cycle pulses
    input  wire logic        irq_ack_zero,
    input  wire logic        irq_ack_one,
    // overflow flags
    output logic             overflow_flag_zero,
    output logic             overflow_flag_one
);
    import dtc_pkg::*;

    // one count step of a timer in the given mode
    function automatic dtc_step_s dtc_step(input dtc_mode_e mode,
                                           input dtc_cnt_s  cnt,
                                           input logic      inc);
        dtc_step_s r;
        r.cnt = cnt;
        r.ovf = 1'b0;
        if (inc) begin
            unique case (mode)
                DTC_MODE_PRESCALE: begin
                    r.cnt.lo[4:0] = cnt.lo[4:0] + 5'h01;
                    if (cnt.lo[4:0] == DTC_PRE_MAX) begin
                        r.cnt.hi = cnt.hi + 8'h01;
                        r.ovf    = (cnt.hi == 8'hff);
                    end
                end
                DTC_MODE_WIDE: begin
                    r.cnt = cnt + 16'h0001;
                    r.ovf = (cnt == 16'hffff);
                end
                DTC_MODE_RELOAD: begin
                    r.cnt.lo = (cnt.lo == 8'hff) ? cnt.hi : cnt.lo + 8'h01;
                    r.ovf    = (cnt.lo == 8'hff);
                end
                DTC_MODE_SPLIT: begin
                    r.cnt.lo = cnt.lo + 8'h01;
                    r.ovf    = (cnt.lo == 8'hff);
                end
            endcase
        end
        return r;
    endfunction : dtc_step

    // pin synchronisers: irq zero, irq one, count zero, count one
    logic [3:0] pin_raw;
    logic [3:0] pin_lvl;
    logic [3:0] pin_fall;

    assign pin_raw = {count_input_one, count_input_zero, ext_irq_pin_one, ext_irq_pin_zero};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            dtc_pin_sync u_sync (
                .hclk    (hclk),
                .hresetn (hresetn),
                .pin     (pin_raw[gi]),
                .level   (pin_lvl[gi]),
                .fall    (pin_fall[gi])
            );
        end
    endgenerate

    // internal tick divider
    logic [3:0] div_reg;
    logic [3:0] div_next;
    logic       tick;

    always_comb begin
        tick     = (div_reg == DTC_TICK_MAX);
        div_next = tick ? 4'h0 : div_reg + 4'h1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_next;
        end
    end

    // ahb address phase capture
    logic       wr_pend_reg;
    logic       wr_pend_next;
    logic [7:0] wr_idx_reg;
    logic [7:0] wr_idx_next;
    logic       rd_take;
    logic       hit;

    always_comb begin
        hit          = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
        rd_take      = hsel && hready && htrans[1] && !hwrite;
        wr_pend_next = hsel && hready && htrans[1] && hwrite && hit;
        wr_idx_next  = haddr[9:2];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 8'h00;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg  <= wr_idx_next;
        end
    end

    // timer state
    logic [7:0] mode_reg;
    logic [7:0] mode_next;
    dtc_cnt_s   t0_reg;
    dtc_cnt_s   t0_next;
    dtc_cnt_s   t1_reg;
    dtc_cnt_s   t1_next;
    logic       run0_reg;
    logic       run0_next;
    logic       run1_reg;
    logic       run1_next;
    logic       ovf0_reg;
    logic       ovf0_next;
    logic       ovf1_reg;
    logic       ovf1_next;

    // counting, register writes and flag updates
    always_comb begin
        dtc_mode_e m0;
        dtc_mode_e m1;
        logic      en0;
        logic      en1;
        logic      inc0;
        logic      inc1;
        logic      hi_inc;
        logic      set0;
        logic      set1;
        logic [7:0] wd;
        dtc_step_s s0;
        dtc_step_s s1;
        m0     = dtc_mode_e'(mode_reg[DTC_MODE_M_ZERO_HI:DTC_MODE_M_ZERO_LO]);
        m1     = dtc_mode_e'(mode_reg[DTC_MODE_M_ONE_HI:DTC_MODE_M_ONE_LO]);
        en0    = run0_reg && (!mode_reg[DTC_MODE_GATE_ZERO] || pin_lvl[0]);
        en1    = run1_reg && (!mode_reg[DTC_MODE_GATE_ONE] || pin_lvl[1]);
        inc0   = en0 && (mode_reg[DTC_MODE_SEL_ZERO] ? pin_fall[2] : tick);
        inc1   = en1 && (mode_reg[DTC_MODE_SEL_ONE] ? pin_fall[3] : tick);
        inc1   = inc1 && (m1 != DTC_MODE_SPLIT);
        s0     = dtc_step(m0, t0_reg, inc0);
        s1     = dtc_step(m1, t1_reg, inc1);
        // split mode: timer zero high byte runs on ticks under run one
        hi_inc = (m0 == DTC_MODE_SPLIT) && run1_reg && tick;
        if (hi_inc) begin
            s0.cnt.hi = t0_reg.hi + 8'h01;
        end
        set0   = s0.ovf;
        // in split mode the high byte of timer zero owns flag one
        set1   = (m0 == DTC_MODE_SPLIT) ? (hi_inc && t0_reg.hi == 8'hff) : s1.ovf;
        wd     = hwdata[7:0];
        t0_next   = s0.cnt;
        t1_next   = s1.cnt;
        mode_next = mode_reg;
        run0_next = run0_reg;
        run1_next = run1_reg;
        ovf0_next = ovf0_reg && !irq_ack_zero;
        ovf1_next = ovf1_reg && !irq_ack_one;
        // a software write wins over a count in the same cycle
        if (wr_pend_reg) begin
            unique case (wr_idx_reg)
                DTC_IDX_MODE:  mode_next = wd;
                DTC_IDX_T0_LO: t0_next.lo = wd;
                DTC_IDX_T0_HI: t0_next.hi = wd;
                DTC_IDX_T1_LO: t1_next.lo = wd;
                DTC_IDX_T1_HI: t1_next.hi = wd;
                DTC_IDX_CTRL: begin
                    ovf1_next = wd[DTC_CTRL_OVF_ONE];
                    run1_next = wd[DTC_CTRL_RUN_ONE];
                    ovf0_next = wd[DTC_CTRL_OVF_ZERO];
                    run0_next = wd[DTC_CTRL_RUN_ZERO];
                end
                default: ;
            endcase
        end
        // hardware set wins over any clear
        if (set0) begin
            ovf0_next = 1'b1;
        end
        if (set1) begin
            ovf1_next = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= DTC_RST_BYTE;
            t0_reg   <= {DTC_RST_BYTE, DTC_RST_BYTE};
            t1_reg   <= {DTC_RST_BYTE, DTC_RST_BYTE};
            run0_reg <= 1'b0;
            run1_reg <= 1'b0;
            ovf0_reg <= 1'b0;
            ovf1_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            t0_reg   <= t0_next;
            t1_reg   <= t1_next;
            run0_reg <= run0_next;
            run1_reg <= run1_next;
            ovf0_reg <= ovf0_next;
            ovf1_reg <= ovf1_next;
        end
    end

    // read data from next values, so a write just before is seen
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic [7:0]  ctrl_view;

    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[DTC_CTRL_OVF_ONE]  = ovf1_next;
        ctrl_view[DTC_CTRL_RUN_ONE]  = run1_next;
        ctrl_view[DTC_CTRL_OVF_ZERO] = ovf0_next;
        ctrl_view[DTC_CTRL_RUN_ZERO] = run0_next;
        hrdata_next = 32'h0000_0000;
        if (rd_take && hit) begin
            unique case (haddr[9:2])
                DTC_IDX_CTRL:  hrdata_next = {24'h00_0000, ctrl_view};
                DTC_IDX_MODE:  hrdata_next = {24'h00_0000, mode_next};
                DTC_IDX_T0_LO: hrdata_next = {24'h00_0000, t0_next.lo};
                DTC_IDX_T0_HI: hrdata_next = {24'h00_0000, t0_next.hi};
                DTC_IDX_T1_LO: hrdata_next = {24'h00_0000, t1_next.lo};
                DTC_IDX_T1_HI: hrdata_next = {24'h00_0000, t1_next.hi};
                default:       hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else begin
            hrdata_reg <= hrdata_next;
        end
    end

    // bus answer: zero wait states, always okay
    logic hreadyout_reg;
    logic hresp_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
    end

    // outputs straight from flops
    assign hrdata             = hrdata_reg;
    assign hreadyout          = hreadyout_reg;
    assign hresp              = hresp_reg;
    assign overflow_flag_zero = ovf0_reg;
    assign overflow_flag_one  = ovf1_reg;
endmodule : dtc_top
`default_nettype wire

// *** dtc_pkg.sv ***
// shared constants and types for the dual timer/counter block
package dtc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] DTC_IDX_CTRL  = 8'h88;
    localparam logic [7:0] DTC_IDX_MODE  = 8'h89;
    localparam logic [7:0] DTC_IDX_T0_LO = 8'h8a;
    localparam logic [7:0] DTC_IDX_T1_LO = 8'h8b;
    localparam logic [7:0] DTC_IDX_T0_HI = 8'h8c;
    localparam logic [7:0] DTC_IDX_T1_HI = 8'h8d;

    // mode-control field positions
    localparam int DTC_MODE_GATE_ONE = 7;
    localparam int DTC_MODE_SEL_ONE  = 6;
    localparam int DTC_MODE_M_ONE_HI = 5;
    localparam int DTC_MODE_M_ONE_LO = 4;
    localparam int DTC_MODE_GATE_ZERO = 3;
    localparam int DTC_MODE_SEL_ZERO = 2;
    localparam int DTC_MODE_M_ZERO_HI = 1;
    localparam int DTC_MODE_M_ZERO_LO = 0;

    // control register field positions
    localparam int DTC_CTRL_OVF_ONE  = 7;
    localparam int DTC_CTRL_RUN_ONE  = 6;
    localparam int DTC_CTRL_OVF_ZERO = 5;
    localparam int DTC_CTRL_RUN_ZERO = 4;

    // reset values
    localparam logic [7:0] DTC_RST_BYTE = 8'h00;

    // internal count rate: one tick every so many hclk cycles
    localparam int         DTC_TICK_DIV = 12;
    localparam logic [3:0] DTC_TICK_MAX = 4'(DTC_TICK_DIV - 1);

    // prescaled mode: five-bit prescaler in the low byte
    localparam logic [4:0] DTC_PRE_MAX = 5'h1f;

    // ahb transfer type
    localparam logic [1:0] DTC_HTRANS_NONSEQ = 2'h2;

    // counting modes
    typedef enum logic [1:0] {
        DTC_MODE_PRESCALE = 2'h0,
        DTC_MODE_WIDE     = 2'h1,
        DTC_MODE_RELOAD   = 2'h2,
        DTC_MODE_SPLIT    = 2'h3
    } dtc_mode_e;

    // one timer's count
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } dtc_cnt_s;

    // result of one count step
    typedef struct packed {
        dtc_cnt_s cnt;
        logic     ovf;
    } dtc_step_s;
endpackage : dtc_pkg

// *** dtc_pin_sync.sv ***
// two-flop synchroniser with falling-edge detect for one pin
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sync (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // pin side
    input  wire logic pin,
    // synchronised side
    output logic      level,
    output logic      fall
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // only sync_reg reads meta_reg
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // level and one-cycle falling pulse
    assign level = sync_reg;
    assign fall  = last_reg & ~sync_reg;
endmodule : dtc_pin_sync
`default_nettype wire

// *** dtc_assertions.sv ***
// checker for the dual timer/counter register slave and flags
`timescale 1ns/1ps
`default_nettype none
module dtc_assertions
    import dtc_pkg::*;
(
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // flags
    input wire logic        overflow_flag_zero,
    input wire logic        overflow_flag_one
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       act;
    logic       wr_mode_next, wr_mode_reg;
    logic [7:0] mode_next, mode_reg;
    // address phase taken at this edge
    assign act = hsel && hready && htrans[1];
    // shadow of the mode byte, updated in the write data phase
    always_comb begin
        wr_mode_next = act && hwrite && haddr == 32'h224;
        mode_next    = wr_mode_reg ? hwdata[7:0] : mode_reg;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_mode_reg <= 1'b0;
            mode_reg    <= 8'h00;
        end else begin
            wr_mode_reg <= wr_mode_next;
            mode_reg    <= mode_next;
        end
    end
    // address phases of interest
    sequence ctrl_wr;
        act && hwrite && haddr == 32'h220;
    endsequence
    sequence rd_at(logic [31:0] a);
        act && !hwrite && haddr == a;
    endsequence
    ready_always_a: assert property (hreadyout) else $error("slave not ready");
    resp_okay_a: assert property (!hresp) else $error("error response");
    rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    unmapped_read_a: assert property (rd_at(32'h238) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    idle_rdata_a: assert property (!(act && !hwrite) |=> hrdata == 32'h0)
        else $error("read data outside read");
    mode_readback_a: assert property (rd_at(32'h224) |=> hrdata[7:0] == mode_reg)
        else $error("mode byte read mismatch");
    flag_zero_set_a: assert property (ctrl_wr ##1 hwdata[DTC_CTRL_OVF_ZERO]
        |=> overflow_flag_zero) else $error("flag zero not set");
    flag_one_set_a: assert property (ctrl_wr ##1 hwdata[DTC_CTRL_OVF_ONE]
        |=> overflow_flag_one) else $error("flag one not set");
endmodule : dtc_assertions
bind dtc_top dtc_assertions i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .overflow_flag_zero(overflow_flag_zero),
    .overflow_flag_one(overflow_flag_one)
);
`default_nettype wire

// *** dtc_pin_model.sv ***
// far-side pin model: gate levels and count pulses
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
    // clock
    input  wire logic hclk,
    // requests from the bench
    input  wire logic fire_zero,
    input  wire logic fire_one,
    input  wire logic gate_zero,
    input  wire logic gate_one,
    // pins toward the block
    output logic      ext_irq_pin_zero,
    output logic      ext_irq_pin_one,
    output logic      count_input_zero,
    output logic      count_input_one
);
    logic [1:0] low_zero = 2'h0;
    logic [1:0] low_one  = 2'h0;
    // each request gives a low pulse of three cycles, idle high
    always_ff @(posedge hclk) begin
        low_zero <= fire_zero ? 2'h3 : low_zero - {1'b0, low_zero != 2'h0};
        low_one  <= fire_one ? 2'h3 : low_one - {1'b0, low_one != 2'h0};
    end
    assign count_input_zero = low_zero == 2'h0;
    assign count_input_one  = low_one == 2'h0;
    // gate levels as the bench asks
    assign ext_irq_pin_zero = gate_zero;
    assign ext_irq_pin_one  = gate_one;
endmodule : dtc_pin_model
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dtc_pkg::*;
    // mode, ctrl, low, high, expected low, expected high, opt
    // opt: bit4 timer one, bit1 gate level, bit0 flag expected
    typedef struct packed {
        logic [7:0] mode, ctrl, lo, hi, elo, ehi, opt;
    } dtc_row_s;
    dtc_row_s rows [10] = '{
        56'h0510ffff000003,
        56'h0610ff80808003,
        56'h0410ff00e00102,
        56'h0d101234123400,
        56'h0d101234133402,
        56'h05001234123402,
        56'h5040ffff000013,
        56'hd0401000100010,
        56'h70401000100012,
        56'h0710fe55ff5502
    };
    dtc_row_s    r;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, la;
    logic [1:0]  htrans = 2'h0;
    logic        hready, hreadyout, hresp, ack0 = 1'b0, ack1 = 1'b0;
    logic        fire0 = 1'b0, fire1 = 1'b0, gate0 = 1'b1, gate1 = 1'b1;
    logic        irq0, irq1, cin0, cin1, flag0, flag1;
    int          fails = 0, comparisons = 0;
    // clock and single-slave ready
    always #2 hclk = ~hclk;
    assign hready = hreadyout;
    dtc_top i_dtc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin_zero(irq0),
        .ext_irq_pin_one(irq1), .count_input_zero(cin0), .count_input_one(cin1),
        .irq_ack_zero(ack0), .irq_ack_one(ack1), .overflow_flag_zero(flag0),
        .overflow_flag_one(flag1));
    dtc_pin_model i_dtc_pin_model (.hclk(hclk), .fire_zero(fire0), .fire_one(fire1),
        .gate_zero(gate0), .gate_one(gate1), .ext_irq_pin_zero(irq0),
        .ext_irq_pin_one(irq1), .count_input_zero(cin0), .count_input_one(cin1));
    task automatic check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // bounded wait for hready at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            fails++;
            end_sim();
        end
    endtask : wait_ready
    // one single word transfer; read data lands in rd
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= DTC_HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= w;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : ahb
    // one falling edge on a count pin, then settle
    task automatic pulse(input logic t);
        if (t) fire1 <= 1'b1;
        else fire0 <= 1'b1;
        @(posedge hclk);
        fire0 <= 1'b0;
        fire1 <= 1'b0;
        repeat (12) @(posedge hclk);
    endtask : pulse
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 'h220; a <= 'h234; a += 4) begin
            ahb(1'b0, 32'(a), 32'h0);
            check("reset value", rd, 32'h0);
        end
        foreach (rows[i]) begin
            r = rows[i];
            la = r.opt[4] ? 32'h22c : 32'h228;
            ahb(1'b1, 32'h220, 32'h0);
            ahb(1'b1, la, {24'h0, r.lo});
            ahb(1'b1, la + 32'h8, {24'h0, r.hi});
            ahb(1'b1, 32'h224, {24'h0, r.mode});
            gate0 <= r.opt[1];
            gate1 <= r.opt[1];
            ahb(1'b1, 32'h220, {24'h0, r.ctrl});
            repeat (4) @(posedge hclk);
            pulse(r.opt[4]);
            ahb(1'b0, la, 32'h0);
            check("low byte", rd, {24'h0, r.elo});
            ahb(1'b0, la + 32'h8, 32'h0);
            check("high byte", rd, {24'h0, r.ehi});
            check("flag", {31'h0, r.opt[4] ? flag1 : flag0}, {31'h0, r.opt[0]});
            if (r.opt[0]) begin
                if (r.opt[4]) ack1 <= 1'b1;
                else ack0 <= 1'b1;
                @(posedge hclk);
                ack0 <= 1'b0;
                ack1 <= 1'b0;
                @(posedge hclk);
                check("flag after ack", {31'h0, r.opt[4] ? flag1 : flag0}, 32'h0);
            end
        end
        // mode read back, unmapped place, software flag set
        ahb(1'b1, 32'h224, 32'ha5);
        ahb(1'b0, 32'h224, 32'h0);
        check("mode byte", rd, 32'ha5);
        ahb(1'b1, 32'h238, 32'hff);
        ahb(1'b0, 32'h238, 32'h0);
        check("unmapped", rd, 32'h0);
        ahb(1'b1, 32'h220, 32'ha0);
        // flags land at the data-phase edge, look one edge later
        @(posedge hclk);
        check("flags by write", {30'h0, flag1, flag0}, 32'h3);
        // split mode from the internal clock, both halves running
        ahb(1'b1, 32'h220, 32'h0);
        @(posedge hclk);
        check("flags cleared by write", {30'h0, flag1, flag0}, 32'h0);
        ahb(1'b1, 32'h228, 32'h0);
        ahb(1'b1, 32'h230, 32'hff);
        ahb(1'b1, 32'h224, 32'h03);
        ahb(1'b1, 32'h220, 32'h50);
        repeat (120) @(posedge hclk);
        ahb(1'b0, 32'h228, 32'h0);
        check("tick low", {31'h0, rd[7:0] inside {[8'h09:8'h0b]}}, 32'h1);
        ahb(1'b0, 32'h230, 32'h0);
        check("tick high", {31'h0, rd[7:0] inside {[8'h09:8'h0b]}}, 32'h1);
        // high byte wrapped from ffh on its first tick: flag one only
        check("split high flag", {30'h0, flag1, flag0}, 32'h2);
        // timer one from the internal clock in the sixteen-bit mode
        ahb(1'b1, 32'h220, 32'h0);
        ahb(1'b1, 32'h22c, 32'h0);
        ahb(1'b1, 32'h234, 32'h0);
        ahb(1'b1, 32'h224, 32'h10);
        ahb(1'b1, 32'h220, 32'h40);
        repeat (120) @(posedge hclk);
        ahb(1'b0, 32'h22c, 32'h0);
        check("tick one low", {31'h0, rd[7:0] inside {[8'h0a:8'h0b]}}, 32'h1);
        // reset in mid-run clears everything
        ahb(1'b1, 32'h220, 32'hf0);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check("flags in reset", {30'h0, flag1, flag0}, 32'h0);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h228, 32'h0);
        check("low after reset", rd, 32'h0);
        end_sim();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
